// [hw/sadma_top.sv]
// Four short address DMA channels with Wishbone registers and a transfer sequencer.
`timescale 1ns/100ps
// What this block does
// RULE1 - Both upper select bits set on A side joins the pair into one channel.
// RULE2 - Memory address is four bytes; top byte ignores writes, reads all ones.
// RULE3 - Memory address is destination for receive-full activation, else source.
// RULE4 - I/O address byte is the low byte; upper sixteen bits are all ones.
// RULE5 - I/O address is source for receive-full activation, else destination.
// RULE6 - Transfers never change the I/O address register.
// RULE7 - Address and count registers survive reset and standby; control clears.
// RULE8 - I/O and idle modes decrement the 16-bit count; zero ends the run.
// RULE9 - Repeat mode decrements the high byte, reloading it from the low byte.
// RULE10 - Control registers clear to zero on reset and standby.
// RULE11 - Enabled channel transfers once per activation; disabled ignores requests.
// RULE12 - Enable is set only by writing one after reading it as zero.
// RULE13 - I/O and idle modes clear enable after the last transfer.
// RULE14 - Clearing enable with interrupt enable set raises the end interrupt.
// RULE15 - Size bit selects byte or word transfers.
// RULE16 - I/O and repeat modes step memory address up or down by 1 or 2.
// RULE17 - Idle mode holds the memory address fixed.
// RULE18 - Mode comes from the repeat and interrupt-enable bits.
// RULE19 - Select codes pick timer, serial or request pin activation sources.
// RULE20 - Channels sharing one source are served one after another by priority.
// RULE21 - An enabled channel blocks its activation source's CPU interrupt; request pin selects 6 and 7 block nothing.
// RULE22 - Joined pair uses A memory address as source, B as destination.
// RULE23 - External requests reach only B side channels in short address mode.
// RULE24 - Priority order is 0A, 0B, 1A, 1B.
module sadma_top (
	input logic clk_sys_in,
	input logic reset_in,
	input logic standby_in,
	input logic wb_cyc_in,
	input logic wb_stb_in,
	input logic wb_we_in,
	input logic [7:0] wb_adr_in,
	input logic [3:0] wb_sel_in,
	input logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input logic [3:0] timer_match_in,
	input logic serial_tx_empty_in,
	input logic serial_rx_full_in,
	input logic [1:0] external_request_pin_n_in,
	output sadma_pkg::sadma_xfer_t xfer_req_out,
	output logic xfer_valid_out,
	input logic xfer_done_in,
	output logic [3:0] transfer_end_irq_out,
	output logic [5:0] source_irq_block_out,
	output logic [1:0] full_mode_out
);
	logic [23:0] mar_q [0:3];
	logic [7:0] io_address_low_byte_q [0:3];
	logic [15:0] cnt_q [0:3];
	logic [7:0] ctrl_q [0:3];
	logic [3:0] armed_q;
	logic [3:0] pend_q;
	logic [3:0] ended_q;
	logic [3:0] irq_q;
	logic [5:0] block_q;
	logic [1:0] full_q;
	logic [1:0] pin_meta_q;
	logic [1:0] pin_sync_q;
	logic [1:0] pin_prev_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic valid_q;
	logic [1:0] chan_q;
	sadma_pkg::sadma_xfer_t xfer_q;
	sadma_pkg::sadma_state_t state_q;
	sadma_pkg::sadma_xfer_t cand_w [0:3];
	logic [5:0] blk_w [0:3];
	logic [7:0] rbyte_w;

	function automatic sadma_pkg::sadma_mode_t mode_of(input logic [7:0] c);
		if (!c[sadma_pkg::SADMA_BIT_REPEAT])
			return sadma_pkg::SADMA_MODE_IO;
		else if (!c[sadma_pkg::SADMA_BIT_IRQEN])
			return sadma_pkg::SADMA_MODE_REPEAT;
		else
			return sadma_pkg::SADMA_MODE_IDLE;
	endfunction

	function automatic logic [1:0] index_of(input logic [3:0] oh);
		return {oh[3] | oh[2], oh[3] | oh[1]};
	endfunction

	// Register bus. Writes and read side effects happen at the ack edge.
	wire logic req_w = wb_cyc_in & wb_stb_in;
	wire logic acc_w = req_w & ack_q;
	wire logic mapped_w = ~wb_adr_in[7];
	wire logic [1:0] bus_ch_w = wb_adr_in[6:5];
	wire logic [2:0] bus_sub_w = wb_adr_in[4:2];
	wire logic wr_w = acc_w & wb_we_in & wb_sel_in[0] & mapped_w;
	wire logic rd_w = acc_w & ~wb_we_in & mapped_w;
	wire logic [7:0] wdat_w = wb_dat_in[7:0];

	always_comb
	begin
		case (bus_sub_w)
			sadma_pkg::SADMA_SUB_RESERVED: rbyte_w = sadma_pkg::SADMA_RESERVED_BYTE; // RULE2
			sadma_pkg::SADMA_SUB_EXT: rbyte_w = mar_q[bus_ch_w][23:16];
			sadma_pkg::SADMA_SUB_HIGH: rbyte_w = mar_q[bus_ch_w][15:8];
			sadma_pkg::SADMA_SUB_LOW: rbyte_w = mar_q[bus_ch_w][7:0];
			sadma_pkg::SADMA_SUB_CNT_HI: rbyte_w = cnt_q[bus_ch_w][15:8];
			sadma_pkg::SADMA_SUB_CNT_LO: rbyte_w = cnt_q[bus_ch_w][7:0];
			sadma_pkg::SADMA_SUB_IO: rbyte_w = io_address_low_byte_q[bus_ch_w];
			default: rbyte_w = ctrl_q[bus_ch_w];
		endcase
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= req_w & ~ack_q;
			if (req_w & ~ack_q)
				dat_q <= {24'h000000, mapped_w ? rbyte_w : 8'h00};
		end
	end

	// Request pins are asynchronous; the edge detector reads only synced bits.
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			pin_meta_q <= sadma_pkg::SADMA_PIN_IDLE;
			pin_sync_q <= sadma_pkg::SADMA_PIN_IDLE;
			pin_prev_q <= sadma_pkg::SADMA_PIN_IDLE;
		end
		else
		begin
			pin_meta_q <= external_request_pin_n_in;
			pin_sync_q <= pin_meta_q;
			pin_prev_q <= pin_sync_q;
		end
	end

	wire logic [1:0] pin_fall_w = pin_prev_q & ~pin_sync_q;
	wire logic [1:0] pin_low_w = ~pin_sync_q;
	wire logic [1:0] full_w = {
		ctrl_q[2][sadma_pkg::SADMA_BIT_SEL_HI] & ctrl_q[2][sadma_pkg::SADMA_BIT_SEL_LO],
		ctrl_q[0][sadma_pkg::SADMA_BIT_SEL_HI] & ctrl_q[0][sadma_pkg::SADMA_BIT_SEL_LO]
	}; // RULE1

	// Arbiter: lowest index wins, so channels sharing a source serialise.
	wire logic idle_w = state_q == sadma_pkg::SADMA_ST_IDLE;
	wire logic [3:0] gnt_w = idle_w ? (pend_q & (~pend_q + 4'h1)) : 4'h0; // RULE20 RULE24
	wire logic [1:0] gnt_idx_w = index_of(gnt_w);
	wire logic fin_w = (state_q == sadma_pkg::SADMA_ST_BUSY) & xfer_done_in;
	wire logic [3:0] done_w = fin_w ? 4'(4'h1 << chan_q) : 4'h0;

	for (genvar g = 0; g < sadma_pkg::SADMA_CHANNELS; g++)
	begin : g_chan
		localparam int PAIR = g / 2;
		localparam bit IS_B = (g % 2) == 1;
		wire logic [7:0] c_w = ctrl_q[g];
		wire logic [2:0] sel_w = c_w[2:0];
		wire logic full_pair_w = full_w[PAIR];
		wire sadma_pkg::sadma_mode_t mode_w = mode_of(c_w); // RULE18
		wire logic rx_w = sel_w == sadma_pkg::SADMA_SEL_RX_FULL;
		wire logic [23:0] io_w = {sadma_pkg::SADMA_IO_UPPER, io_address_low_byte_q[g]}; // RULE4
		logic evt_w;
		logic [7:0] ctrl_d;

		always_comb
		begin
			evt_w = 1'b0;
			if (full_pair_w)
				evt_w = !IS_B && pin_fall_w[PAIR];
			else if (!sel_w[2])
				evt_w = timer_match_in[sel_w[1:0]]; // RULE19
			else if (sel_w == sadma_pkg::SADMA_SEL_TX_EMPTY)
				evt_w = serial_tx_empty_in;
			else if (rx_w)
				evt_w = serial_rx_full_in;
			else if (IS_B)
				evt_w = (sel_w == sadma_pkg::SADMA_SEL_PIN_EDGE) ?
					pin_fall_w[PAIR] : pin_low_w[PAIR]; // RULE19 RULE23
		end

		// The joined pair only runs through its A side, whose select is 6 or 7.
		assign cand_w[g].chan = 2'(g);
		assign cand_w[g].word = c_w[sadma_pkg::SADMA_BIT_SIZE]; // RULE15
		assign cand_w[g].src = full_pair_w ? mar_q[g] :
			(rx_w ? io_w : mar_q[g]); // RULE3 RULE5 RULE22
		assign cand_w[g].dst = full_pair_w ? mar_q[g ^ 1] :
			(rx_w ? mar_q[g] : io_w); // RULE3 RULE5 RULE22
		assign blk_w[g] = c_w[sadma_pkg::SADMA_BIT_ENABLE] ?
			6'(6'h01 << sel_w) : 6'h00; // RULE21

		wire logic [23:0] step_w = c_w[sadma_pkg::SADMA_BIT_SIZE] ?
			sadma_pkg::SADMA_STEP_WORD : sadma_pkg::SADMA_STEP_BYTE;
		wire logic [23:0] mar_next_w = c_w[sadma_pkg::SADMA_BIT_DIR] ?
			mar_q[g] - step_w : mar_q[g] + step_w; // RULE16
		wire logic short_done_w = done_w[g] & ~full_pair_w;
		wire logic move_w = short_done_w &
			(mode_w != sadma_pkg::SADMA_MODE_IDLE); // RULE17
		wire logic [15:0] cnt_dec_w = cnt_q[g] - sadma_pkg::SADMA_CNT_ONE;
		wire logic [7:0] hi_dec_w = cnt_q[g][15:8] - sadma_pkg::SADMA_HI_ONE;
		wire logic rep_w = mode_w == sadma_pkg::SADMA_MODE_REPEAT;
		wire logic last_w = short_done_w & ~rep_w & (cnt_dec_w == 16'h0000); // RULE13
		wire logic hit_w = wr_w & (bus_ch_w == 2'(g));
		wire logic ctrl_wr_w = hit_w & (bus_sub_w == sadma_pkg::SADMA_SUB_CTRL);
		wire logic ctrl_rd_w = rd_w & (bus_ch_w == 2'(g)) &
			(bus_sub_w == sadma_pkg::SADMA_SUB_CTRL);
		wire logic en_wr_w = wdat_w[sadma_pkg::SADMA_BIT_ENABLE] &
			(armed_q[g] | c_w[sadma_pkg::SADMA_BIT_ENABLE]); // RULE12
		wire logic ended_d = ~ctrl_d[sadma_pkg::SADMA_BIT_ENABLE] &
			(c_w[sadma_pkg::SADMA_BIT_ENABLE] | ended_q[g]);

		// A software write wins over the automatic clear in the same cycle.
		always_comb
		begin
			ctrl_d = c_w;
			if (last_w)
				ctrl_d[sadma_pkg::SADMA_BIT_ENABLE] = 1'b0; // RULE13
			if (ctrl_wr_w)
				ctrl_d = {en_wr_w, wdat_w[6:0]};
		end

		// No reset here: these contents must survive reset and standby.
		always_ff @(posedge clk_sys_in)
		begin
			if (move_w)
				mar_q[g] <= mar_next_w; // RULE16
			if (short_done_w & rep_w)
				cnt_q[g][15:8] <= (hi_dec_w == 8'h00) ? cnt_q[g][7:0] : hi_dec_w; // RULE9
			else if (short_done_w)
				cnt_q[g] <= cnt_dec_w; // RULE8
			if (hit_w & (bus_sub_w == sadma_pkg::SADMA_SUB_EXT))
				mar_q[g][23:16] <= wdat_w;
			if (hit_w & (bus_sub_w == sadma_pkg::SADMA_SUB_HIGH))
				mar_q[g][15:8] <= wdat_w;
			if (hit_w & (bus_sub_w == sadma_pkg::SADMA_SUB_LOW))
				mar_q[g][7:0] <= wdat_w;
			if (hit_w & (bus_sub_w == sadma_pkg::SADMA_SUB_CNT_HI))
				cnt_q[g][15:8] <= wdat_w;
			if (hit_w & (bus_sub_w == sadma_pkg::SADMA_SUB_CNT_LO))
				cnt_q[g][7:0] <= wdat_w;
			if (hit_w & (bus_sub_w == sadma_pkg::SADMA_SUB_IO))
				io_address_low_byte_q[g] <= wdat_w; // RULE6
		end

		always_ff @(posedge clk_sys_in)
		begin
			if (reset_in | standby_in)
			begin
				ctrl_q[g] <= sadma_pkg::SADMA_CTRL_RESET; // RULE7 RULE10
				armed_q[g] <= 1'b0;
				pend_q[g] <= 1'b0;
				ended_q[g] <= 1'b0;
				irq_q[g] <= 1'b0;
			end
			else
			begin
				ctrl_q[g] <= ctrl_d;
				if (ctrl_wr_w)
					armed_q[g] <= 1'b0;
				else if (ctrl_rd_w & ~c_w[sadma_pkg::SADMA_BIT_ENABLE])
					armed_q[g] <= 1'b1; // RULE12
				pend_q[g] <= ctrl_d[sadma_pkg::SADMA_BIT_ENABLE] &
					((c_w[sadma_pkg::SADMA_BIT_ENABLE] & evt_w) |
					(pend_q[g] & ~gnt_w[g])); // RULE11
				ended_q[g] <= ended_d;
				irq_q[g] <= ended_d & ctrl_d[sadma_pkg::SADMA_BIT_IRQEN]; // RULE14
			end
		end
	end

	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in | standby_in)
		begin
			state_q <= sadma_pkg::SADMA_ST_IDLE;
			valid_q <= 1'b0;
			chan_q <= 2'h0;
			xfer_q <= '0;
			block_q <= 6'h00;
			full_q <= 2'h0;
		end
		else
		begin
			block_q <= blk_w[0] | blk_w[1] | blk_w[2] | blk_w[3];
			full_q <= full_w;
			case (state_q)
				sadma_pkg::SADMA_ST_IDLE:
					if (|gnt_w)
					begin
						xfer_q <= cand_w[gnt_idx_w];
						chan_q <= gnt_idx_w;
						valid_q <= 1'b1;
						state_q <= sadma_pkg::SADMA_ST_BUSY;
					end
				sadma_pkg::SADMA_ST_BUSY:
					if (xfer_done_in)
					begin
						valid_q <= 1'b0;
						state_q <= sadma_pkg::SADMA_ST_IDLE;
					end
				default:
					state_q <= sadma_pkg::SADMA_ST_IDLE;
			endcase
		end
	end

	assign wb_ack_out = ack_q;
	assign wb_dat_out = dat_q;
	assign xfer_req_out = xfer_q;
	assign xfer_valid_out = valid_q;
	assign transfer_end_irq_out = irq_q;
	assign source_irq_block_out = block_q;
	assign full_mode_out = full_q;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);

	wire logic quiet0_w = ~(wr_w & (bus_ch_w == 2'h0));

	sequence s_grant0;
		idle_w && gnt_w[0];
	endsequence
	sequence s_busy0;
		xfer_valid_out && (xfer_req_out.chan == 2'h0);
	endsequence

	property p_full_blocks_b;
		full_w[0] |-> !gnt_w[1] ##1 !(xfer_valid_out && xfer_req_out.chan == 2'h1 && $rose(xfer_valid_out));
	endproperty
	a_full_blocks_b: assert property (p_full_blocks_b) else $error("B side granted in full mode"); // RULE1

	property p_reserved_ones;
		(req_w && !ack_q && !wb_we_in && mapped_w && bus_sub_w == 3'h0) |=> wb_dat_out[7:0] == 8'hFF;
	endproperty
	a_reserved_ones: assert property (p_reserved_ones) else $error("reserved byte not all ones"); // RULE2

	property p_rx_roles;
		s_grant0 ##0 (ctrl_q[0][2:0] == 3'h5 && !full_w[0]) |=> s_busy0 ##0
			(xfer_req_out.dst == $past(mar_q[0])) && (xfer_req_out.src[23:8] == 16'hFFFF);
	endproperty
	a_rx_roles: assert property (p_rx_roles) else $error("wrong roles for receive-full"); // RULE3

	property p_tx_roles;
		s_grant0 ##0 (ctrl_q[0][2:0] == 3'h4) |=> s_busy0 ##0
			(xfer_req_out.src == $past(mar_q[0])) && (xfer_req_out.dst == {16'hFFFF, $past(io_address_low_byte_q[0])});
	endproperty
	a_tx_roles: assert property (p_tx_roles) else $error("wrong roles for transmit-empty"); // RULE5

	property p_io_fixed;
		(quiet0_w && done_w[0]) |=> $stable(io_address_low_byte_q[0]);
	endproperty
	a_io_fixed: assert property (p_io_fixed) else $error("I/O address moved"); // RULE6

	property p_count_dec;
		(done_w[0] && quiet0_w && !full_w[0] && !ctrl_q[0][4]) |=> cnt_q[0] == $past(cnt_q[0]) - 16'h0001;
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("count not decremented"); // RULE8

	property p_repeat_reload;
		(done_w[0] && quiet0_w && !full_w[0] && mode_of(ctrl_q[0]) == sadma_pkg::SADMA_MODE_REPEAT
			&& cnt_q[0][15:8] == 8'h01) |=> cnt_q[0][15:8] == cnt_q[0][7:0];
	endproperty
	a_repeat_reload: assert property (p_repeat_reload) else $error("repeat count not reloaded"); // RULE9

	property p_ctrl_reset;
		disable iff (1'b0) (reset_in || standby_in) |=> ctrl_q[0] == 8'h00 && ctrl_q[3] == 8'h00;
	endproperty
	a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared"); // RULE10

	property p_no_pend_disabled;
		!ctrl_q[1][7] |-> !pend_q[1];
	endproperty
	a_no_pend_disabled: assert property (p_no_pend_disabled) else $error("pending while disabled"); // RULE11

	property p_set_needs_read;
		(wr_w && bus_ch_w == 2'h0 && bus_sub_w == 3'h7 && wdat_w[7] && !armed_q[0] && !ctrl_q[0][7])
			|=> !ctrl_q[0][7];
	endproperty
	a_set_needs_read: assert property (p_set_needs_read) else $error("enable set without read"); // RULE12

	property p_end_irq;
		(done_w[0] && quiet0_w && !full_w[0] && ctrl_q[0][4:3] == 2'h3 && cnt_q[0] == 16'h0001)
			|=> !ctrl_q[0][7] && transfer_end_irq_out[0];
	endproperty
	a_end_irq: assert property (p_end_irq) else $error("idle mode end missing"); // RULE13 RULE14

	property p_idle_hold;
		(done_w[0] && quiet0_w && ctrl_q[0][4:3] == 2'h3) |=> $stable(mar_q[0]);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle mode moved address"); // RULE17

	property p_word_step;
		(done_w[0] && quiet0_w && !full_w[0] && ctrl_q[0][6:3] == 4'h8) |=> mar_q[0] == $past(mar_q[0]) + 24'h000002;
	endproperty
	a_word_step: assert property (p_word_step) else $error("word step wrong"); // RULE15 RULE16

	property p_priority;
		(idle_w && pend_q[0] && pend_q[1]) |=> xfer_req_out.chan == 2'h0 ##1 pend_q[1][*1];
	endproperty
	a_priority: assert property (p_priority) else $error("priority order broken"); // RULE20 RULE24

	property p_block_src;
		disable iff (reset_in || standby_in)
		(ctrl_q[2][7] && ctrl_q[2][2:0] == 3'h4) |=> source_irq_block_out[4];
	endproperty
	a_block_src: assert property (p_block_src) else $error("source not blocked"); // RULE21
endmodule

// [hw/sadma_pkg.sv]
// Constants, types and register map of the short address DMA channel block.
package sadma_pkg;
	localparam int SADMA_CHANNELS = 4;
	// Register index equals printed offset minus this base; byte address = 4 * index.
	localparam logic [15:0] SADMA_OFFSET_BASE = 16'hFF20;
	localparam logic [15:0] SADMA_OFFSET_LAST = 16'hFF3F;
	// Low three index bits select a byte register within a channel.
	localparam logic [2:0] SADMA_SUB_RESERVED = 3'h0;
	localparam logic [2:0] SADMA_SUB_EXT = 3'h1;
	localparam logic [2:0] SADMA_SUB_HIGH = 3'h2;
	localparam logic [2:0] SADMA_SUB_LOW = 3'h3;
	localparam logic [2:0] SADMA_SUB_CNT_HI = 3'h4;
	localparam logic [2:0] SADMA_SUB_CNT_LO = 3'h5;
	localparam logic [2:0] SADMA_SUB_IO = 3'h6;
	localparam logic [2:0] SADMA_SUB_CTRL = 3'h7;
	// Control register fields.
	localparam int SADMA_BIT_ENABLE = 7;
	localparam int SADMA_BIT_SIZE = 6;
	localparam int SADMA_BIT_DIR = 5;
	localparam int SADMA_BIT_REPEAT = 4;
	localparam int SADMA_BIT_IRQEN = 3;
	localparam int SADMA_BIT_SEL_HI = 2;
	localparam int SADMA_BIT_SEL_LO = 1;
	localparam logic [7:0] SADMA_CTRL_RESET = 8'h00;
	localparam logic [7:0] SADMA_RESERVED_BYTE = 8'hFF;
	localparam logic [15:0] SADMA_IO_UPPER = 16'hFFFF;
	// Activation source codes.
	localparam logic [2:0] SADMA_SEL_TX_EMPTY = 3'h4;
	localparam logic [2:0] SADMA_SEL_RX_FULL = 3'h5;
	localparam logic [2:0] SADMA_SEL_PIN_EDGE = 3'h6;
	localparam logic [2:0] SADMA_SEL_PIN_LEVEL = 3'h7;
	localparam logic [23:0] SADMA_STEP_BYTE = 24'h000001;
	localparam logic [23:0] SADMA_STEP_WORD = 24'h000002;
	localparam logic [15:0] SADMA_CNT_ONE = 16'h0001;
	localparam logic [7:0] SADMA_HI_ONE = 8'h01;
	localparam logic [1:0] SADMA_PIN_IDLE = 2'h3;

	typedef enum logic [1:0] {
		SADMA_MODE_IO,
		SADMA_MODE_REPEAT,
		SADMA_MODE_IDLE
	} sadma_mode_t;

	typedef enum logic {
		SADMA_ST_IDLE,
		SADMA_ST_BUSY
	} sadma_state_t;

	typedef struct packed {
		logic [1:0] chan;
		logic word;
		logic [23:0] src;
		logic [23:0] dst;
	} sadma_xfer_t;
endpackage

// [verification/sadma_bus_model.sv]
// Bus-side partner that completes each granted transfer after a set wait.
`timescale 1ns/100ps
module sadma_bus_model (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic xfer_valid_in,
	input wire logic [3:0] wait_cycles_in,
	output logic xfer_done_out
);
	logic [3:0] wait_q;

	// The done pulse lasts one cycle; a request still held afterwards is completed again after another wait.
	always_ff @(posedge clk_sys_in)
	begin
		if (reset_in || !xfer_valid_in || xfer_done_out)
		begin
			wait_q <= 4'h0;
			xfer_done_out <= 1'b0;
		end
		else if (wait_q >= wait_cycles_in)
		begin
			xfer_done_out <= 1'b1;
		end
		else
		begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule

// [verification/tb.sv]
// Self-checking bench for the short address DMA channel block.
`timescale 1ns/100ps
`define CHECK(a, b) \
	begin check_count++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic stby = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [3:0] tmr = 4'h0;
	logic txe = 1'b0;
	logic rxf = 1'b0;
	logic [1:0] pin_n = 2'h3;
	sadma_pkg::sadma_xfer_t req;
	sadma_pkg::sadma_xfer_t exp;
	logic valid;
	logic done;
	logic [3:0] irq;
	logic [5:0] blk;
	logic [1:0] full;
	logic [3:0] slow = 4'h0;
	logic [31:0] got;
	int n_errors = 0;
	int check_count = 0;

	always #20 clk = ~clk;

	sadma_top sadma_top_inst (.clk_sys_in(clk), .reset_in(rst),
		.standby_in(stby), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .timer_match_in(tmr),
		.serial_tx_empty_in(txe), .serial_rx_full_in(rxf),
		.external_request_pin_n_in(pin_n), .xfer_req_out(req),
		.xfer_valid_out(valid), .xfer_done_in(done),
		.transfer_end_irq_out(irq), .source_irq_block_out(blk),
		.full_mode_out(full));

	sadma_bus_model sadma_bus_model_inst (.clk_sys_in(clk), .reset_in(rst),
		.xfer_valid_in(valid), .wait_cycles_in(slow),
		.xfer_done_out(done));

	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Entered just after a rising edge; holds the request until ack is seen.
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		wdat <= {24'h000000, d};
		for (i = 0; i < 20; i++)
		begin
			@(posedge clk);
			if (ack === 1'b1)
				break;
		end
		if (i == 20)
		begin
			n_errors++;
			print_verdict();
		end
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input int ch, input int sub, input logic [7:0] d);
		wb({1'b0, ch[1:0], sub[2:0], 2'b00}, 1'b1, d);
	endtask

	task automatic rdc(input int ch, input int sub, input logic [7:0] e);
		wb({1'b0, ch[1:0], sub[2:0], 2'b00}, 1'b0, 8'h00);
		`CHECK(got, {24'h000000, e})
	endtask

	task automatic setup(input int ch, input logic [23:0] m,
		input logic [15:0] c, input logic [7:0] io);
		wr(ch, 1, m[23:16]);
		wr(ch, 2, m[15:8]);
		wr(ch, 3, m[7:0]);
		wr(ch, 4, c[15:8]);
		wr(ch, 5, c[7:0]);
		wr(ch, 6, io);
	endtask

	// Enable is accepted only after a read that saw it clear.
	task automatic enable(input int ch, input logic [7:0] ctl);
		rdc(ch, 7, 8'h00);
		wr(ch, 7, ctl);
		rdc(ch, 7, ctl);
	endtask

	task automatic xfer(input logic [1:0] ch, input logic w,
		input logic [23:0] s, input logic [23:0] d);
		int i;
		exp = '{chan: ch, word: w, src: s, dst: d};
		for (i = 0; i < 20 && valid !== 1'b1; i++)
			@(posedge clk);
		if (i == 20)
		begin
			n_errors++;
			print_verdict();
		end
		`CHECK(req, exp)
		for (i = 0; i < 20 && valid !== 1'b0; i++)
			@(posedge clk);
		if (i == 20)
		begin
			n_errors++;
			print_verdict();
		end
		`CHECK(valid, 1'b0)
		repeat (3) @(posedge clk);
	endtask

	task automatic pulse_timer(input logic [3:0] t);
		tmr <= t;
		@(posedge clk);
		tmr <= 4'h0;
		@(posedge clk);
	endtask

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(0, 7, 8'h00);
		rdc(3, 7, 8'h00);
		wr(1, 0, 8'h12);
		rdc(1, 0, 8'hFF);
		wb(8'h84, 1'b1, 8'h55);
		wb(8'h84, 1'b0, 8'h00);
		`CHECK(got, 32'h0)
		wr(0, 7, 8'h06);
		repeat (3) @(posedge clk);
		`CHECK(full, 2'b01)
		wr(0, 7, 8'h00);
		// I/O mode, byte, incrementing, timer 0, two transfers.
		setup(0, 24'h001000, 16'h0002, 8'h34);
		wr(0, 7, 8'h88);
		rdc(0, 7, 8'h08);
		wr(0, 7, 8'h88);
		rdc(0, 7, 8'h88);
		@(posedge clk);
		`CHECK(blk[0], 1'b1)
		pulse_timer(4'h1);
		xfer(2'd0, 1'b0, 24'h001000, 24'hFFFF34);
		rdc(0, 3, 8'h01);
		rdc(0, 5, 8'h01);
		rdc(0, 6, 8'h34);
		`CHECK(irq[0], 1'b0)
		slow <= 4'h5;
		pulse_timer(4'h1);
		xfer(2'd0, 1'b0, 24'h001001, 24'hFFFF34);
		rdc(0, 7, 8'h08);
		`CHECK(irq[0], 1'b1)
		`CHECK(blk[0], 1'b0)
		rdc(0, 4, 8'h00);
		pulse_timer(4'h1);
		repeat (4)
		begin
			`CHECK(valid, 1'b0)
			@(posedge clk);
		end
		slow <= 4'h0;
		// Receive-full on 0B: word, decrementing, I/O side is the source.
		setup(1, 24'h002000, 16'h0005, 8'h56);
		enable(1, 8'hE5);
		rxf <= 1'b1;
		@(posedge clk);
		rxf <= 1'b0;
		xfer(2'd1, 1'b1, 24'hFFFF56, 24'h002000);
		rdc(1, 2, 8'h1F);
		rdc(1, 3, 8'hFE);
		// Receive-full shared by 0A and 0B: 0A goes first, word steps up.
		setup(0, 24'h005000, 16'h0001, 8'h34);
		wr(0, 7, 8'h00);
		enable(0, 8'hC5);
		rxf <= 1'b1;
		@(posedge clk);
		rxf <= 1'b0;
		xfer(2'd0, 1'b1, 24'hFFFF34, 24'h005000);
		rdc(0, 3, 8'h02);
		rdc(1, 3, 8'hFC);
		// Idle mode on 0A from transmit-empty: address held, end raised.
		wr(0, 5, 8'h01);
		wr(0, 7, 8'h00);
		enable(0, 8'h9C);
		txe <= 1'b1;
		@(posedge clk);
		txe <= 1'b0;
		xfer(2'd0, 1'b0, 24'h005002, 24'hFFFF34);
		rdc(0, 3, 8'h02);
		`CHECK(irq[0], 1'b1)
		// Repeat mode on 0A: the high count byte reloads from the low byte.
		wr(0, 4, 8'h01);
		wr(0, 5, 8'h03);
		wr(0, 7, 8'h00);
		enable(0, 8'h90);
		pulse_timer(4'h1);
		xfer(2'd0, 1'b0, 24'h005002, 24'hFFFF34);
		rdc(0, 4, 8'h03);
		rdc(0, 3, 8'h03);
		// Repeat mode on 1A from transmit-empty: high byte reloads.
		setup(2, 24'h003000, 16'h0102, 8'h78);
		enable(2, 8'h94);
		txe <= 1'b1;
		@(posedge clk);
		txe <= 1'b0;
		xfer(2'd2, 1'b0, 24'h003000, 24'hFFFF78);
		rdc(2, 4, 8'h02);
		rdc(2, 7, 8'h94);
		rdc(2, 3, 8'h01);
		// Idle mode on 1B from a low request pin: address held, ends.
		setup(3, 24'h004000, 16'h0001, 8'h9A);
		enable(3, 8'h9F);
		pin_n <= 2'b01;
		repeat (2) @(posedge clk);
		pin_n <= 2'b11;
		xfer(2'd3, 1'b0, 24'h004000, 24'hFFFF9A);
		rdc(3, 3, 8'h00);
		rdc(3, 7, 8'h1F);
		`CHECK(irq[3], 1'b1)
		// Joined pair 1: a falling pin edge moves from A's address to B's.
		wr(2, 7, 8'h00);
		enable(2, 8'h86);
		pin_n <= 2'b01;
		repeat (2) @(posedge clk);
		pin_n <= 2'b11;
		xfer(2'd2, 1'b0, 24'h003001, 24'h004000);
		`CHECK(full, 2'b10)
		// Standby clears control but keeps addresses and counts.
		wr(3, 7, 8'h00);
		enable(3, 8'h9F);
		stby <= 1'b1;
		repeat (2) @(posedge clk);
		stby <= 1'b0;
		@(posedge clk);
		rdc(3, 7, 8'h00);
		rdc(3, 2, 8'h40);
		rdc(2, 5, 8'h02);
		rdc(0, 6, 8'h34);
		print_verdict();
	end

	initial
	begin
		#2000000;
		n_errors++;
		print_verdict();
	end
endmodule
